// File: design/pced_pkg.sv
// pin change edge detector: constants, register map and carrier types
// assumes an apb slave on a 250 MHz single clock and six external pins
//
// How it works
// - Each of the six pins has a rising-edge enable bit in bits 5..0.
// - Each pin has a falling-edge enable bit in a separate register.
// - A rising edge on a pin with its rise enable set sets its flag.
// - A falling edge on a pin with its fall enable set sets its flag.
// - An enabled edge that sets a flag whose mask bit is set also raises the summary irq.
// - With both enables clear a pin's transitions leave its flag alone.
// - A flag stays at one until software writes zero to it.
// - Flags are read/write and a hardware set wins over any write.
// - Bits 7 and 6 of all four registers read zero, ignore writes.
// - Every reset clears all enable and flag bits.
package pced_pkg;
  localparam int NPINS = 6;
  localparam logic [7:0] ADDR_RISE = 8'h00;
  localparam logic [7:0] ADDR_FALL = 8'h04;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0c;
  localparam logic [5:0] PINS_RESET = 6'h00;
  localparam logic [5:0] MASK_RESET = 6'h3f;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } pced_req_t;

  typedef struct packed {
    logic [5:0] rise;
    logic [5:0] fall;
  } pced_enables_t;
endpackage

// File: design/pced_sync.sv
// pin change edge detector: two-flop synchroniser plus edge finder
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
module pced_sync
  import pced_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // pins
  input wire logic [NPINS-1:0] port_pin,
  // edges, one-cycle pulses
  output logic [NPINS-1:0] rise_pulse,
  output logic [NPINS-1:0] fall_pulse
);
  logic [NPINS-1:0] meta_reg;
  logic [NPINS-1:0] sync_reg;
  logic [NPINS-1:0] prev_reg;

  // the first stage feeds only the second one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= PINS_RESET;
      sync_reg <= PINS_RESET;
      prev_reg <= PINS_RESET;
    end else begin
      meta_reg <= port_pin;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NPINS; i++) begin : g_edge
      assign rise_pulse[i] = sync_reg[i] & ~prev_reg[i];
      assign fall_pulse[i] = ~sync_reg[i] & prev_reg[i];
    end
  endgenerate
endmodule

// File: design/pced_top.sv
// pin change edge detector: apb registers, flags and summary interrupt
// assumes an apb master on sys_clk and pins from outside the clock domain
`timescale 1ns/1ps
module pced_top
  import pced_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic [NPINS-1:0] port_pin,
  // interrupt
  output logic change_summary_irq
);
  logic rst_meta_reg;
  logic rst_n;
  pced_req_t req;
  pced_enables_t en_reg;
  logic [NPINS-1:0] flag_reg;
  logic [NPINS-1:0] flag_next;
  logic [NPINS-1:0] mask_reg;
  logic [NPINS-1:0] rise_pulse;
  logic [NPINS-1:0] fall_pulse;
  logic [NPINS-1:0] hw_set;
  logic wr_en;
  logic mapped;

  // reset release is synchronised, assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  pced_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port_pin(port_pin),
    .rise_pulse(rise_pulse),
    .fall_pulse(fall_pulse)
  );

  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign mapped = (req.addr == ADDR_RISE) || (req.addr == ADDR_FALL) ||
                  (req.addr == ADDR_FLAG) || (req.addr == ADDR_MASK);
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & req.write & mapped;

  // enables: only bits 5..0 are stored, upper bits are dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_reg.rise <= PINS_RESET;
      en_reg.fall <= PINS_RESET;
    end else if (wr_en) begin
      if (req.addr == ADDR_RISE) begin
        en_reg.rise <= req.wdata[NPINS-1:0];
      end
      if (req.addr == ADDR_FALL) begin
        en_reg.fall <= req.wdata[NPINS-1:0];
      end
    end
  end

  // mask gates flags onto the irq; resets open so the summary works at once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_reg <= MASK_RESET;
    end else if (wr_en && req.addr == ADDR_MASK) begin
      mask_reg <= req.wdata[NPINS-1:0];
    end
  end

  // a pin with both enables clear never produces a set
  assign hw_set = (rise_pulse & en_reg.rise) |
                  (fall_pulse & en_reg.fall);

  // flags: software write stores the value, hardware set wins the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (wr_en && req.addr == ADDR_FLAG) begin
      flag_next = req.wdata[NPINS-1:0];
    end
    flag_next = flag_next | hw_set;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= PINS_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      change_summary_irq <= 1'b0;
    end else begin
      change_summary_irq <= |(flag_next & mask_reg);
    end
  end

  // read data registered off the setup cycle so it is valid in access
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= RD_ZERO;
    end else if (psel && !penable && !req.write) begin
      case (req.addr)
        ADDR_RISE: prdata <= {26'h0, en_reg.rise};
        ADDR_FALL: prdata <= {26'h0, en_reg.fall};
        ADDR_FLAG: prdata <= {26'h0, flag_next};
        ADDR_MASK: prdata <= {26'h0, mask_reg};
        default: prdata <= RD_ZERO;
      endcase
    end
  end

  a_rise_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(rise_pulse & en_reg.rise) |=> |flag_reg)
    else $error("enabled rising edge did not set a flag");
  a_fall_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(fall_pulse & en_reg.fall) |=> |flag_reg)
    else $error("enabled falling edge did not set a flag");
  a_irq_follows_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(hw_set & mask_reg) |=> change_summary_irq)
    else $error("summary irq missing after an enabled edge");
  a_disabled_pin_quiet: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    (!(wr_en && req.addr == ADDR_FLAG) &&
     ((en_reg.rise | en_reg.fall) == 6'h00))
    |=> flag_reg == $past(flag_reg))
    else $error("flag changed with all edges disabled");
  a_flag_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!(wr_en && req.addr == ADDR_FLAG)) |=> (flag_reg & $past(flag_reg))
    == $past(flag_reg))
    else $error("flag dropped without a software clear");
  a_set_beats_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |hw_set |=> (flag_reg & $past(hw_set)) == $past(hw_set))
    else $error("hardware set lost against a write");
  a_upper_rise_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && !pwrite && paddr == ADDR_RISE
    |-> prdata[7:6] == 2'h0 && prdata[5:0] == en_reg.rise)
    else $error("rise enable readback wrong");
  a_fall_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && !pwrite && paddr == ADDR_FALL
    |-> prdata[7:0] == {2'h0, en_reg.fall})
    else $error("fall enable readback wrong");
  a_reset_clears: assert property (@(posedge sys_clk)
    $rose(rst_n) |-> flag_reg == 6'h00 && en_reg == 12'h000)
    else $error("registers not cleared by reset");
  a_sync_two_stage: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |rise_pulse |-> |$past(port_pin, 2))
    else $error("edge seen without synchroniser delay");
endmodule

// File: sim/pced_pins.sv
// pin driver model for the pin change edge detector
// assumes the bench sets want; pins move just after a clock edge
`timescale 1ns/1ps
module pced_pins
  import pced_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // requested and driven pin levels
  input wire logic [NPINS-1:0] want,
  output logic [NPINS-1:0] port_pin
);
  initial port_pin = '0;
  // levels held many cycles so the synchroniser never misses one
  always @(posedge sys_clk) port_pin <= want;
endmodule

// File: sim/tb_pin_change_edge_detector.sv
// self-checking bench for the pin change edge detector
// assumes pced_top with zero-wait apb and the pced_pins model
`timescale 1ns/1ps
module tb_pin_change_edge_detector;
  import pced_pkg::*;
  logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, change_summary_irq;
  logic [NPINS-1:0] want = '0, port_pin;
  logic [31:0] expq[$];
  int failures = 0, checked = 0, i;
  integer seed = 32'h7a32c2f0;
  always #2 sys_clk = ~sys_clk;
  pced_top uut(.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_pin(port_pin), .change_summary_irq(change_summary_irq));
  pced_pins pins(.sys_clk(sys_clk), .want(want), .port_pin(port_pin));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // the irq is registered: look at it away from the edge that launches it
  task chk_irq(input logic e);
    @(negedge sys_clk);
    chk(32'(change_summary_irq), 32'(e));
  endtask
  task close_out;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // read data is taken only at the edge that completes the access
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      chk(32'(pslverr), 32'(!(paddr inside
        {ADDR_RISE, ADDR_FALL, ADDR_FLAG, ADDR_MASK})));
      if (!pwrite && expq.size() > 0)
        chk(prdata, expq.pop_front());
    end
  end
  task pins_to(input logic [5:0] p, input logic [31:0] e);
    @(posedge sys_clk);
    want <= p;
    repeat (8) @(posedge sys_clk);
    rd(ADDR_FLAG, e);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    close_out;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1;
    repeat (3) @(posedge sys_clk);
    rd(ADDR_RISE, 32'h0);
    rd(ADDR_FALL, 32'h0);
    rd(ADDR_FLAG, 32'h0);
    rd(ADDR_MASK, 32'h3f);
    rd(8'h10, 32'h0);
    apb(1'b1, ADDR_RISE, 32'hffff_ffff);
    rd(ADDR_RISE, 32'h3f);
    apb(1'b1, ADDR_FALL, 32'hffff_ffc0);
    rd(ADDR_FALL, 32'h0);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      apb(1'b1, ADDR_FALL, r);
      rd(ADDR_FALL, r & 32'h3f);
    end
    apb(1'b1, ADDR_RISE, 32'h15);
    apb(1'b1, ADDR_FALL, 32'h2a);
    pins_to(6'h3f, 32'h15);
    chk_irq(1'b1);
    pins_to(6'h00, 32'h3f);
    apb(1'b1, ADDR_FLAG, 32'h0);
    rd(ADDR_FLAG, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, ADDR_RISE, 32'h0);
    apb(1'b1, ADDR_FALL, 32'h0);
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      pins_to(r[5:0], 32'h0);
    end
    apb(1'b1, ADDR_MASK, 32'h0);
    apb(1'b1, ADDR_FLAG, 32'hffff_ffe1);
    rd(ADDR_FLAG, 32'h21);
    chk_irq(1'b0);
    apb(1'b1, ADDR_MASK, 32'h3f);
    repeat (2) @(posedge sys_clk);
    chk_irq(1'b1);
    close_out;
  end
endmodule
